/* File: vss_regs.sv */
// Output setpoint, margin setpoint and summary status registers of the converter.
//
// What this block does
// - Setpoint code is a mantissa with exponent -9, about 1.9531 mV per code.
// - Nominal setpoint is 10 bits, supported range 307 to 614.
// - Output target moves one code per strap-selected 4, 8, 16 or 32 us.
// - Margin-high state uses the upper margin setpoint as target.
// - Margin-low state uses the lower margin setpoint as target.
// - Margin setpoints are two bytes, same format, range 307 to 614.
// - Off flag at bit 6 reads 0 while the converter drives its output.
// - Off flag reads 1 when commanded off or tri-stated by a fault.
// - Bit 5 reads 1 after an output overvoltage fault.
// - Bit 4 reads 1 after an output overcurrent fault.
// - Bit 3 reads 1 after an input undervoltage fault.
// - Bit 2 reads 1 after any temperature fault or warning.
// - Bit 1 reads 1 after a communication, memory or logic fault.
// - Bit 0 reads 1 after any other fault or warning; bit 7 unused.
// - Margin field: 00xx off, 0101/0110 low, 1001/1010 high.
// - Clear faults clears flag bits 5 to 0 and alert; present faults set again.
module vss_regs import vss_pkg::*; (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Command port
    input wire logic cmd_wr_en,
    input wire logic cmd_rd_en,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    output logic [15:0] rd_data,
    output logic rd_valid,
    output logic rd_unmapped,
    // Pin straps
    input wire logic [9:0] strap_setpoint,
    input wire logic [1:0] strap_slew_sel,
    // Operation control
    input wire logic unit_on,
    input wire logic [3:0] margin_select_field,
    // Fault and warning events
    input wire logic output_overvoltage_protection,
    input wire logic output_overcurrent_fault,
    input wire logic input_undervoltage_event,
    input wire logic temperature_event,
    input wire logic comm_memory_logic_event,
    input wire logic other_event,
    // Output tri-state causes
    input wire logic output_undervoltage_fault,
    input wire logic overtemperature_shutdown,
    input wire logic supply_lockout,
    // Results
    output logic [9:0] vout_target,
    output logic [9:0] vout_goal,
    output logic [7:0] summary_status,
    output logic strap_done,
    output logic alert_n
);

    // Decodes the margin select field into the chosen target.
    // margin field decode
    function automatic vss_sel_type margin_decode(input logic [3:0] f);
        vss_sel_type s;
        s = VSS_SEL_NOMINAL;
        if ((f == MARGIN_LOW_IGNORE) || (f == MARGIN_LOW_ACT)) begin
            s = VSS_SEL_LOW;
        end else if ((f == MARGIN_HIGH_IGNORE) || (f == MARGIN_HIGH_ACT)) begin
            s = VSS_SEL_HIGH;
        end
        return s;
    endfunction

    // Limits a code to the supported range.
    function automatic logic [9:0] range_limit(input logic [9:0] c);
        logic [9:0] r;
        r = c;
        if (c < SETPOINT_MIN) begin
            r = SETPOINT_MIN;
        end else if (c > SETPOINT_MAX) begin
            r = SETPOINT_MAX;
        end
        return r;
    endfunction

    vss_state_type state_q, state_d;
    logic [1:0] settle_q, settle_d;
    logic [11:0] strap_s1_q, strap_s2_q, strap_s3_q;
    logic [SETPOINT_W-1:0] nominal_q, nominal_d;
    logic [SETPOINT_W-1:0] upper_q, upper_d;
    logic [SETPOINT_W-1:0] lower_q, lower_d;
    logic [1:0] slew_sel_q, slew_sel_d;
    logic [STICKY_W-1:0] flags_q, flags_d;
    logic off_q, off_d;
    logic alert_q, alert_d;
    logic [WORD_W-1:0] rd_data_q, rd_data_d;
    logic rd_valid_q, rd_valid_d;
    logic rd_unmapped_q, rd_unmapped_d;
    logic [SETPOINT_W-1:0] goal;
    logic [INTERVAL_W-1:0] interval;
    logic [STICKY_W-1:0] events;
    logic wr_ok, clear_faults, strap_load;
    logic [STATUS_W-1:0] status_word;

    // Strap pins pass three flip-flops; only stages two and three are used.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            strap_s1_q <= '0;
            strap_s2_q <= '0;
            strap_s3_q <= '0;
        end else begin
            strap_s1_q <= {strap_slew_sel, strap_setpoint};
            strap_s2_q <= strap_s1_q;
            strap_s3_q <= strap_s2_q;
        end
    end

    // Writes are refused until the straps are captured, so a host write
    // cannot be overwritten by the late strap load.
    assign wr_ok = cmd_wr_en && (state_q == VSS_ST_RUN);
    assign clear_faults = wr_ok && (cmd_code == CMD_CLEAR_FAULTS);

    // Events in status bit order, bit 5 down to bit 0.
    assign events = {output_overvoltage_protection, output_overcurrent_fault,
                     input_undervoltage_event, temperature_event,
                     comm_memory_logic_event, other_event};

    // Next values of the strap, setpoint and status state.
    always_comb begin
        state_d = state_q;
        settle_d = settle_q;
        strap_load = 1'b0;
        nominal_d = nominal_q;
        upper_d = upper_q;
        lower_d = lower_q;
        slew_sel_d = slew_sel_q;
        case (state_q)
            VSS_ST_STRAP: begin
                if (settle_q != STRAP_SETTLE) begin
                    settle_d = settle_q + 2'h1;
                end else if (strap_s2_q == strap_s3_q) begin
                    strap_load = 1'b1;
                    nominal_d = strap_s3_q[SETPOINT_W-1:0];
                    upper_d = strap_s3_q[SETPOINT_W-1:0];
                    lower_d = strap_s3_q[SETPOINT_W-1:0];
                    slew_sel_d = strap_s3_q[SETPOINT_W+1:SETPOINT_W];
                    state_d = VSS_ST_RUN;
                end
            end
            VSS_ST_RUN: begin
                if (wr_ok && (cmd_code == CMD_OUTPUT_SETPOINT)) begin
                    nominal_d = cmd_wdata[SETPOINT_W-1:0];
                end
                if (wr_ok && (cmd_code == CMD_UPPER_MARGIN_SETPOINT)) begin
                    upper_d = cmd_wdata[SETPOINT_W-1:0];
                end
                if (wr_ok && (cmd_code == CMD_LOWER_MARGIN_SETPOINT)) begin
                    lower_d = cmd_wdata[SETPOINT_W-1:0];
                end
            end
            default: begin
                state_d = VSS_ST_STRAP;
            end
        endcase
        flags_d = (clear_faults ? '0 : flags_q) | events;
        alert_d = (clear_faults ? 1'b0 : alert_q) | (|events);
        off_d = !unit_on || output_undervoltage_fault || overtemperature_shutdown
                || supply_lockout;
    end

    // Registers of the strap, setpoint and status state.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= VSS_ST_STRAP;
            settle_q <= '0;
            nominal_q <= '0;
            upper_q <= '0;
            lower_q <= '0;
            slew_sel_q <= '0;
            flags_q <= '0;
            off_q <= 1'b1;
            alert_q <= 1'b0;
        end else begin
            state_q <= state_d;
            settle_q <= settle_d;
            nominal_q <= nominal_d;
            upper_q <= upper_d;
            lower_q <= lower_d;
            slew_sel_q <= slew_sel_d;
            flags_q <= flags_d;
            off_q <= off_d;
            alert_q <= alert_d;
        end
    end

    assign status_word = {1'b0, off_q, flags_q};

    // Read answers one cycle after the request; unknown codes read zero.
    always_comb begin
        rd_data_d = rd_data_q;
        rd_valid_d = cmd_rd_en;
        rd_unmapped_d = 1'b0;
        if (cmd_rd_en) begin
            case (cmd_code)
                CMD_OUTPUT_SETPOINT: rd_data_d = WORD_W'(nominal_q);
                CMD_UPPER_MARGIN_SETPOINT: rd_data_d = WORD_W'(upper_q);
                CMD_LOWER_MARGIN_SETPOINT: rd_data_d = WORD_W'(lower_q);
                CMD_SUMMARY_STATUS: rd_data_d = WORD_W'(status_word);
                default: begin
                    rd_data_d = '0;
                    rd_unmapped_d = 1'b1;
                end
            endcase
        end
    end

    // Registers of the read path.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_data_q <= '0;
            rd_valid_q <= 1'b0;
            rd_unmapped_q <= 1'b0;
        end else begin
            rd_data_q <= rd_data_d;
            rd_valid_q <= rd_valid_d;
            rd_unmapped_q <= rd_unmapped_d;
        end
    end

    // Goal selection; out-of-range codes are held to the supported range
    // so a careless host write cannot drive the loop outside its limits.
    always_comb begin
        case (margin_decode(margin_select_field))
            VSS_SEL_HIGH: goal = range_limit(upper_q);
            VSS_SEL_LOW: goal = range_limit(lower_q);
            default: goal = range_limit(nominal_q);
        endcase
    end

    // Step interval is the 4 us base doubled per strap code.
    assign interval = INTERVAL_W'(SLEW_BASE_CYCLES) << slew_sel_q;

    vss_slew_stepper #(
        .CODE_W(SETPOINT_W),
        .CNT_W(INTERVAL_W)
    ) vss_slew_stepper_inst (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .load(strap_load),
        .load_code(range_limit(strap_s3_q[SETPOINT_W-1:0])),
        .goal_code(goal),
        .interval_cycles(interval),
        .cur_code(vout_target),
        .step_tick()
    );

    assign vout_goal = goal;
    assign summary_status = status_word;
    assign strap_done = (state_q == VSS_ST_RUN);
    assign alert_n = !alert_q;
    assign rd_data = rd_data_q;
    assign rd_valid = rd_valid_q;
    assign rd_unmapped = rd_unmapped_q;

    AST_OV_FLAG_SETS: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        output_overvoltage_protection |=> summary_status[OVERVOLTAGE_SUMMARY_FLAG_BIT])
        else $error("Overvoltage event did not set its status bit.");
    AST_OC_FLAG_HOLDS: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (output_overcurrent_fault ##1 !clear_faults[*3])
        |=> summary_status[OVERCURRENT_SUMMARY_FLAG_BIT])
        else $error("Overcurrent status bit was lost without a clear.");
    AST_CLEAR_ALL: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (clear_faults && (events == '0))
        |=> (summary_status[STICKY_W-1:0] == '0) && alert_n)
        else $error("Clear faults left a flag or the alert set.");
    AST_CLEAR_RESETS: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (clear_faults && temperature_event) |=> summary_status[TEMP_FLAG_BIT] && !alert_n)
        else $error("A present fault was lost by clear faults.");
    AST_OFF_COMMANDED: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (!unit_on || supply_lockout) |=> summary_status[OFF_BIT])
        else $error("Off flag low while commanded off or locked out.");
    AST_ON_DRIVEN: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (unit_on && !output_undervoltage_fault && !overtemperature_shutdown
         && !supply_lockout) |=> !summary_status[OFF_BIT])
        else $error("Off flag high while output is driven.");
    AST_BIT7_ZERO: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        !summary_status[UNUSED_BIT])
        else $error("Unused status bit reads one.");
    AST_MARGIN_HIGH: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (margin_select_field == MARGIN_HIGH_ACT) |-> (vout_goal == range_limit(upper_q)))
        else $error("Margin high did not select the upper margin setpoint.");
    AST_MARGIN_LOW: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (margin_select_field == MARGIN_LOW_IGNORE) |-> (vout_goal == range_limit(lower_q)))
        else $error("Margin low did not select the lower margin setpoint.");

    AST_GOAL_RANGE: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (vout_goal >= SETPOINT_MIN) && (vout_goal <= SETPOINT_MAX))
        else $error("Goal code left the supported range.");

    AST_STATUS_WRITE: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (wr_ok && (cmd_code == CMD_SUMMARY_STATUS) && (events == '0))
        |=> (summary_status[STICKY_W-1:0] == $past(summary_status[STICKY_W-1:0])))
        else $error("Write to summary status changed its flags.");

    AST_SETPOINT_WRITE: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (wr_ok && (cmd_code == CMD_OUTPUT_SETPOINT)) ##1 !cmd_wr_en
        ##1 (cmd_rd_en && (cmd_code == CMD_OUTPUT_SETPOINT) && !cmd_wr_en)
        |=> (rd_data == WORD_W'($past(cmd_wdata[SETPOINT_W-1:0], 3))))
        else $error("Setpoint read-back does not match the masked write.");

endmodule // vss_regs

/* File: vss_pkg.sv */
// Shared constants for the output setpoint and summary status register bank.
package vss_pkg;

    // Command codes of the registers held by this bank.
    localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] CMD_OUTPUT_SETPOINT = 8'h21;
    localparam logic [7:0] CMD_UPPER_MARGIN_SETPOINT = 8'h25;
    localparam logic [7:0] CMD_LOWER_MARGIN_SETPOINT = 8'h26;
    localparam logic [7:0] CMD_SUMMARY_STATUS = 8'h78;

    // Setpoint code format: linear mantissa, fixed exponent, 10 writable bits.
    localparam int VOUT_EXPONENT = -9;
    localparam int SETPOINT_W = 10;
    localparam int WORD_W = 16;
    localparam int STATUS_W = 8;
    localparam logic [9:0] SETPOINT_MIN = 10'h133;
    localparam logic [9:0] SETPOINT_MAX = 10'h266;

    // Summary status bit positions.
    localparam int UNUSED_BIT = 7;
    localparam int OFF_BIT = 6;
    localparam int OVERVOLTAGE_SUMMARY_FLAG_BIT = 5;
    localparam int OVERCURRENT_SUMMARY_FLAG_BIT = 4;
    localparam int INPUT_UNDERVOLTAGE_FLAG_BIT = 3;
    localparam int TEMP_FLAG_BIT = 2;
    localparam int COMM_MEMORY_LOGIC_FLAG_BIT = 1;
    localparam int OTHER_FLAG_BIT = 0;
    localparam int STICKY_W = 6;

    // Margin select field encodings.
    localparam logic [1:0] MARGIN_OFF_HI = 2'h0;
    localparam logic [3:0] MARGIN_LOW_IGNORE = 4'h5;
    localparam logic [3:0] MARGIN_LOW_ACT = 4'h6;
    localparam logic [3:0] MARGIN_HIGH_IGNORE = 4'h9;
    localparam logic [3:0] MARGIN_HIGH_ACT = 4'hA;

    // Step interval timing: 4 us times a power of two chosen by strap.
    localparam int CLK_MHZ = 100;
    localparam int SLEW_BASE_US = 4;
    localparam int SLEW_BASE_CYCLES = SLEW_BASE_US * CLK_MHZ;
    localparam int INTERVAL_W = 16;

    // Strap settling: cycles to let the three-stage synchroniser fill.
    localparam logic [1:0] STRAP_SETTLE = 2'h3;

    // Target selection derived from the margin select field.
    typedef enum logic [1:0] {
        VSS_SEL_NOMINAL,
        VSS_SEL_LOW,
        VSS_SEL_HIGH
    } vss_sel_type;

    // Bank life cycle: wait for straps, then run.
    typedef enum logic {
        VSS_ST_STRAP,
        VSS_ST_RUN
    } vss_state_type;

endpackage

/* File: vss_slew_stepper.sv */
// Moves the output target one code step per step interval toward the goal.
module vss_slew_stepper import vss_pkg::*; #(
    parameter int CODE_W = SETPOINT_W,
    parameter int CNT_W = INTERVAL_W
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Preset and goal
    input wire logic load,
    input wire logic [CODE_W-1:0] load_code,
    input wire logic [CODE_W-1:0] goal_code,
    input wire logic [CNT_W-1:0] interval_cycles,
    // Current target
    output logic [CODE_W-1:0] cur_code,
    output logic step_tick
);

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [CODE_W-1:0] cur_q;
    logic [CODE_W-1:0] cur_d;
    logic tick;

    // The interval counter runs freely, so the first step after a change
    // comes at most one interval later; this keeps the counter trivial.
    always_comb begin
        tick = (cnt_q >= interval_cycles - CNT_W'(1));
        cnt_d = tick ? '0 : cnt_q + CNT_W'(1);
        cur_d = cur_q;
        if (load) begin
            cur_d = load_code;
        end else if (tick && (cur_q < goal_code)) begin
            cur_d = cur_q + CODE_W'(1);
        end else if (tick && (cur_q > goal_code)) begin
            cur_d = cur_q - CODE_W'(1);
        end
    end

    // Registers of the stepper.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= '0;
            cur_q <= '0;
        end else begin
            cnt_q <= cnt_d;
            cur_q <= cur_d;
        end
    end

    assign cur_code = cur_q;
    assign step_tick = tick;

    AST_STEP_ONE_PER_TICK: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (!$past(load) && !$past(tick)) |-> $stable(cur_q))
        else $error("Target moved without a step tick.");

    AST_STEP_SIZE: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        ($past(tick) && !$past(load) && ($past(cur_q) < $past(goal_code)))
        |-> (cur_q == $past(cur_q) + CODE_W'(1)))
        else $error("Target did not step up by exactly one code.");

endmodule // vss_slew_stepper

/* File: vss_host_model.sv */
// Behavioural host controller that issues commands to the register bank.
module vss_host_model (
    // Clock
    input wire logic core_clk,
    // Command port toward the bank
    output logic cmd_wr_en,
    output logic cmd_rd_en,
    output logic [7:0] cmd_code,
    output logic [15:0] cmd_wdata,
    input wire logic [15:0] rd_data,
    input wire logic rd_valid,
    input wire logic rd_unmapped
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle values are arbitrary; after each command the code shows its inverse, after a write the data too.
    initial begin
        cmd_wr_en = 1'b0;
        cmd_rd_en = 1'b0;
        cmd_code = 8'hA5;
        cmd_wdata = 16'h5A5A;
    end

    task automatic wr(input logic [7:0] code, input logic [15:0] data);
        @(posedge core_clk);
        #1;
        cmd_wr_en = 1'b1;
        cmd_code = code;
        cmd_wdata = data;
        @(posedge core_clk);
        #1;
        cmd_wr_en = 1'b0;
        cmd_code = ~code;
        cmd_wdata = ~data;
    endtask

    // The answer is taken in the cycle after the request edge.
    task automatic rd(input logic [7:0] code, output logic [15:0] data, output logic vld,
                      output logic unm);
        @(posedge core_clk);
        #1;
        cmd_rd_en = 1'b1;
        cmd_code = code;
        @(posedge core_clk);
        #1;
        cmd_rd_en = 1'b0;
        cmd_code = ~code;
        data = rd_data;
        vld = rd_valid;
        unm = rd_unmapped;
    endtask
endmodule // vss_host_model

/* File: tb_vss_regs.sv */
// Self-checking testbench of the setpoint and summary status register bank.
module tb_vss_regs;
    import vss_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic cmd_wr_en, cmd_rd_en, rd_valid, rd_unmapped, strap_done, alert_n;
    logic [7:0] cmd_code, summary_status;
    logic [15:0] cmd_wdata, rd_data;
    logic [9:0] vout_target, vout_goal;
    logic unit_on = 1'b1;
    logic [3:0] margin = 4'h0;
    logic [5:0] evt = 6'h00;
    logic [2:0] cause = 3'h0;
    logic [9:0] strap_code = 10'h180;
    logic [1:0] slew_code = 2'h0;
    int fails = 0;
    int total_checks = 0;

    // The straps change only while reset is held, as the bank expects.
    vss_regs vss_regs_inst (.core_clk(core_clk), .reset_n(reset_n), .cmd_wr_en(cmd_wr_en),
        .cmd_rd_en(cmd_rd_en), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rd_data(rd_data),
        .rd_valid(rd_valid), .rd_unmapped(rd_unmapped), .strap_setpoint(strap_code),
        .strap_slew_sel(slew_code), .unit_on(unit_on), .margin_select_field(margin),
        .output_overvoltage_protection(evt[5]), .output_overcurrent_fault(evt[4]),
        .input_undervoltage_event(evt[3]), .temperature_event(evt[2]),
        .comm_memory_logic_event(evt[1]), .other_event(evt[0]),
        .output_undervoltage_fault(cause[0]), .overtemperature_shutdown(cause[1]),
        .supply_lockout(cause[2]), .vout_target(vout_target), .vout_goal(vout_goal),
        .summary_status(summary_status), .strap_done(strap_done), .alert_n(alert_n));

    vss_host_model vss_host_model_inst (.core_clk(core_clk), .cmd_wr_en(cmd_wr_en),
        .cmd_rd_en(cmd_rd_en), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
        .rd_data(rd_data), .rd_valid(rd_valid), .rd_unmapped(rd_unmapped));

    // Free-running 100 MHz clock.
    initial begin
        forever #5 core_clk = ~core_clk;
    end

    task automatic finish_test();
        if (fails == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // A read must answer once; unmapped codes return zero with the flag.
    task automatic rchk(input logic [7:0] code, input logic [15:0] exp, input logic unm_exp);
        logic [15:0] d;
        logic v, u;
        vss_host_model_inst.rd(code, d, v, u);
        check("rd_valid", {15'h0, v}, 16'h0001);
        check("rd_unmapped", {15'h0, u}, {15'h0, unm_exp});
        check("rd_data", d, exp);
    endtask

    // Strap code loads all setpoints; status reads clean once the unit runs.
    task automatic t_strap(input logic [9:0] code);
        int n;
        for (n = 0; n < 50 && strap_done !== 1'b1; n++) @(posedge core_clk);
        if (n >= 50) begin
            fails++;
            finish_test();
        end
        #1;
        rchk(CMD_OUTPUT_SETPOINT, {6'h0, code}, 1'b0);
        rchk(CMD_UPPER_MARGIN_SETPOINT, {6'h0, code}, 1'b0);
        rchk(CMD_LOWER_MARGIN_SETPOINT, {6'h0, code}, 1'b0);
        rchk(CMD_SUMMARY_STATUS, 16'h0000, 1'b0);
        rchk(8'h55, 16'h0000, 1'b1);
    endtask

    // Two steps upward from base; one interval is 400 cycles per 4 us of strap setting.
    task automatic t_slew(input logic [9:0] base, input int per);
        int n;
        vss_host_model_inst.wr(CMD_OUTPUT_SETPOINT, {6'h0, base + 10'h002});
        for (n = 0; n < per + 50 && vout_target === base; n++) @(posedge core_clk) #1;
        check("first step", {6'h0, vout_target}, {6'h0, base + 10'h001});
        for (n = 1; n < per + 50; n++) begin
            @(posedge core_clk) #1;
            if (vout_target !== base + 10'h001) break;
        end
        check("interval", n[15:0], per[15:0]);
        check("second step", {6'h0, vout_target}, {6'h0, base + 10'h002});
        repeat (per + 10) @(posedge core_clk);
        check("settled", {6'h0, vout_target}, {6'h0, base + 10'h002});
    endtask

    // Read-only upper bits are dropped; the four margin codes and three off codes pick their sources.
    task automatic t_margin();
        logic [3:0] codes [7] = '{4'h0, 4'h3, 4'h5, 4'h6, 4'h9, 4'hA, 4'h2};
        logic [9:0] exp [7] = '{10'h200, 10'h200, 10'h140, 10'h140, 10'h260, 10'h260, 10'h200};
        vss_host_model_inst.wr(CMD_UPPER_MARGIN_SETPOINT, 16'h0260);
        vss_host_model_inst.wr(CMD_LOWER_MARGIN_SETPOINT, 16'h0140);
        vss_host_model_inst.wr(CMD_OUTPUT_SETPOINT, 16'hFE00);
        rchk(CMD_OUTPUT_SETPOINT, 16'h0200, 1'b0);
        rchk(CMD_UPPER_MARGIN_SETPOINT, 16'h0260, 1'b0);
        for (int i = 0; i < 7; i++) begin
            margin = codes[i];
            @(posedge core_clk) #1;
            check("vout_goal", {6'h0, vout_goal}, {6'h0, exp[i]});
        end
        margin = 4'h0;
    endtask

    // Each event sets its own flag and alert; clear works unless the event persists.
    task automatic t_flags();
        for (int i = 0; i < 6; i++) begin
            evt = 6'h01 << i;
            @(posedge core_clk) #1;
            evt = 6'h00;
            check("flag", {8'h0, summary_status}, 16'h0001 << i);
            check("alert_n", {15'h0, alert_n}, 16'h0000);
            vss_host_model_inst.wr(CMD_SUMMARY_STATUS, 16'h0000);
            rchk(CMD_SUMMARY_STATUS, 16'h0001 << i, 1'b0);
            vss_host_model_inst.wr(CMD_CLEAR_FAULTS, 16'h0000);
            check("cleared", {8'h0, summary_status}, 16'h0000);
            check("alert off", {15'h0, alert_n}, 16'h0001);
        end
        evt = 6'h04;
        vss_host_model_inst.wr(CMD_CLEAR_FAULTS, 16'h0000);
        check("set again", {8'h0, summary_status}, 16'h0004);
        evt = 6'h00;
        vss_host_model_inst.wr(CMD_CLEAR_FAULTS, 16'h0000);
        check("clear again", {8'h0, summary_status}, 16'h0000);
    endtask

    // Commanded off or any tri-state cause reads off; a driven fault does not.
    task automatic t_off();
        unit_on = 1'b0;
        repeat (2) @(posedge core_clk) #1;
        check("off cmd", {8'h0, summary_status}, 16'h0040);
        unit_on = 1'b1;
        evt = 6'h20;
        repeat (2) @(posedge core_clk) #1;
        evt = 6'h00;
        check("on ovp", {8'h0, summary_status}, 16'h0020);
        vss_host_model_inst.wr(CMD_CLEAR_FAULTS, 16'h0000);
        for (int i = 0; i < 3; i++) begin
            cause = 3'h1 << i;
            repeat (2) @(posedge core_clk) #1;
            check("off cause", {8'h0, summary_status[7:6], 6'h00}, 16'h0040);
            cause = 3'h0;
            repeat (2) @(posedge core_clk) #1;
            check("back on", {8'h0, summary_status[7:6], 6'h00}, 16'h0000);
        end
    endtask

    // A mid-run reset with new straps: reset values return, the strap code below
    // the range is held to the minimum for the target, and steps take 8 us.
    task automatic t_rerun();
        reset_n = 1'b0;
        strap_code = 10'h100;
        slew_code = 2'h1;
        @(posedge core_clk) #1;
        check("reset target", {6'h0, vout_target}, 16'h0000);
        check("reset off", {8'h0, summary_status}, 16'h0040);
        check("reset alert", {15'h0, alert_n}, 16'h0001);
        reset_n = 1'b1;
        t_strap(10'h100);
        check("strap goal", {6'h0, vout_goal}, 16'h0133);
        check("strap target", {6'h0, vout_target}, 16'h0133);
        t_slew(10'h133, 800);
    endtask

    // Reset is held for 12 cycles, then the scenarios run in turn.
    initial begin
        repeat (12) @(posedge core_clk);
        check("reset status", {8'h0, summary_status}, 16'h0040);
        #1;
        reset_n = 1'b1;
        t_strap(10'h180);
        t_slew(10'h180, 400);
        t_margin();
        t_flags();
        t_off();
        t_rerun();
        finish_test();
    end
endmodule // tb_vss_regs
